// ### hw/adc_vol_pkg.sv
package adc_vol_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_LEFT_VOL   = 8'h53;
    localparam logic [7:0] IDX_RIGHT_VOL  = 8'h54;
    localparam logic [7:0] IDX_PHASE      = 8'h55;
    localparam logic [7:0] IDX_AGC1       = 8'h56;
    localparam logic [7:0] IDX_STEP_CTRL  = 8'h60;
    localparam logic [7:0] IDX_STATUS     = 8'h61;

    // Field layout and reset values.
    localparam int         VOL_W          = 7;
    localparam int         AGC_EN_BIT     = 7;
    localparam int         AGC_TGT_LSB    = 4;
    localparam int         AGC_HYST_LSB   = 0;
    localparam logic [6:0] VOL_RESET      = 7'h00;
    localparam logic [7:0] PHASE_RESET    = 8'h00;
    localparam logic [7:0] AGC1_RESET     = 8'h00;
    localparam logic [1:0] STEP_RESET     = 2'h0;
    localparam logic [7:0] AGC1_WMASK     = 8'hF3;

    // Volume code limits in half-decibel steps.
    localparam logic signed [6:0] VOL_MIN = 7'sh67;
    localparam logic signed [6:0] VOL_MAX = 7'sh28;

    // Soft-step modes.
    localparam logic [1:0] STEP_EVERY     = 2'h0;
    localparam logic [1:0] STEP_TWO       = 2'h1;
    localparam logic [1:0] STEP_OFF       = 2'h2;

    // Gain table scale: unity is 2**GAIN_FRAC.
    localparam int         GAIN_FRAC      = 14;

endpackage : adc_vol_pkg

// ### hw/vol_gain_channel.sv
`timescale 1ns/1ps
// One channel: soft-steps the applied volume toward the target code and scales samples.
module vol_gain_channel #(
    parameter int SAMPLE_W = 24
) (
    // Clock and reset.
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    // Control.
    input  wire logic [6:0]                 targetCode,
    input  wire logic [1:0]                 stepMode,
    input  wire logic                       wordTick,
    // Samples.
    input  wire logic signed [SAMPLE_W-1:0] sampleIn,
    output logic signed [SAMPLE_W-1:0]      sampleOut,
    output logic [6:0]                      appliedCode
);

    logic signed [6:0]  applied_q;
    logic               half_q;
    logic signed [6:0]  tgt;
    logic signed [6:0]  tgtClamped;
    logic               stepNow;
    logic [17:0]        gain;
    logic signed [SAMPLE_W+18:0] prod;

    assign tgt = $signed(targetCode);

    // Codes outside the usable span are clamped so a reserved code never gives a wild gain.
    always_comb begin
        if (tgt > adc_vol_pkg::VOL_MAX) begin
            tgtClamped = adc_vol_pkg::VOL_MAX; // R03
        end else if (tgt < adc_vol_pkg::VOL_MIN) begin
            tgtClamped = adc_vol_pkg::VOL_MIN; // R02
        end else begin
            tgtClamped = tgt;
        end
    end

    // Step timing: every word clock, every second one, or immediate.
    assign stepNow = wordTick && (stepMode != adc_vol_pkg::STEP_TWO || half_q); // R13

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            half_q <= 1'b0;
        end else if (wordTick) begin
            half_q <= ~half_q;
        end
    end

    // Applied code walks one half-decibel step at a time unless stepping is off.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            applied_q <= adc_vol_pkg::VOL_RESET; // R06
        end else if (stepMode == adc_vol_pkg::STEP_OFF) begin
            applied_q <= tgtClamped;
        end else if (stepNow && applied_q < tgtClamped) begin
            applied_q <= applied_q + 7'sd1; // R13
        end else if (stepNow && applied_q > tgtClamped) begin
            applied_q <= applied_q - 7'sd1;
        end
    end

    assign appliedCode = applied_q;

    // Linear gain of 10**(code/40) in Q4.14, one entry per half-decibel code.
    // Positive codes step down from an exact gain of ten, so +20 dB carries no rounding drift.
    // The product is kept 32 bits wide because an 18-bit product would wrap before the shift.
    // Codes below -24, the lowest usable one included, stay at 24 steps down, the -12 dB floor.
    function automatic logic [17:0] gainOf(input logic signed [6:0] c);
        logic [31:0] g;
        int          n;
        int          i;
        if (c > 0) begin
            g = 32'h0002_8000; // R03
            n = 40 - int'(c);
        end else begin
            g = 32'h0000_4000; // R01
            n = (-int'(c) > 24) ? 24 : -int'(c); // R02
        end
        for (i = 0; i < 40; i++) begin
            if (i < n) begin
                g = (g * 32'd15468) >> 14; // R01
            end
        end
        return g[17:0];
    endfunction : gainOf

    assign gain = gainOf(applied_q);
    assign prod = sampleIn * $signed({1'b0, gain});

    // Output sample is registered; rounding is truncation, a small bias accepted for size.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sampleOut <= '0;
        end else if (wordTick) begin
            sampleOut <= SAMPLE_W'(prod >>> adc_vol_pkg::GAIN_FRAC); // R14
        end
    end

endmodule : vol_gain_channel

// ### hw/adc_volume_phase_agc_regs.sv
`timescale 1ns/1ps
// Functional notes
// R01: Volume is signed half-decibel code.
// R02: Code 110 0111 gives minus 12 dB.
// R03: Code 010 1000 gives plus 20 dB.
// R04: Right volume same encoding, independent.
// R05: Software avoids reserved volume codes.
// R06: Volumes reset to zero code.
// R07: Reserved bits read zero, write zero.
// R08: Phase zero means no channel delay.
// R09: Negative phase code delays left channel.
// R10: Positive phase code delays right channel.
// R11: AGC enable bit, resets clear.
// R12: Three-bit AGC target level field.
// R13: Volume soft-steps per word clock.
// R14: Volume applied to every ADC sample.
module adc_volume_phase_agc_regs #(
    parameter int SAMPLE_W  = 24,
    parameter int MAX_DELAY = 128
) (
    // Clock and reset.
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    // Wishbone slave.
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [9:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    output logic                            wb_err_o,
    // ADC sample stream, one sample pair per word clock.
    input  wire logic                       wordTick,
    input  wire logic signed [SAMPLE_W-1:0] leftIn,
    input  wire logic signed [SAMPLE_W-1:0] rightIn,
    output logic signed [SAMPLE_W-1:0]      leftOut,
    output logic signed [SAMPLE_W-1:0]      rightOut,
    output logic                            outValid,
    // Settings for the gain control engine.
    output logic                            agcEnable,
    output logic [2:0]                      agcTarget,
    output logic [1:0]                      agcHysteresis
);

    logic [6:0]  leftVol_q;
    logic [6:0]  rightVol_q;
    logic [7:0]  phase_q;
    logic [7:0]  agc1_q;
    logic [1:0]  stepMode_q;
    logic        ack_q;
    logic        err_q;
    logic [31:0] rdat_q;
    logic        req;
    logic        hit;
    logic [7:0]  idx;
    logic        wrLow;
    logic [31:0] rdMux;
    logic [6:0]  leftApplied;
    logic [6:0]  rightApplied;
    logic signed [SAMPLE_W-1:0] leftScaled;
    logic signed [SAMPLE_W-1:0] rightScaled;
    logic        tickDly_q;

    // Word address decode; the two low address bits are ignored and only byte lane 0 is written.
    assign idx   = wb_adr_i[9:2];
    assign req   = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign hit   = (idx == adc_vol_pkg::IDX_LEFT_VOL) || (idx == adc_vol_pkg::IDX_RIGHT_VOL) ||
                   (idx == adc_vol_pkg::IDX_PHASE) || (idx == adc_vol_pkg::IDX_AGC1) ||
                   (idx == adc_vol_pkg::IDX_STEP_CTRL) || (idx == adc_vol_pkg::IDX_STATUS);
    assign wrLow = req && hit && wb_we_i && wb_sel_i[0];

    // Answer one cycle after the request; unmapped addresses get an error instead of an ack.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && hit;
            err_q <= req && !hit;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    // Volume registers; the top bit is not stored so it always reads zero.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            leftVol_q  <= adc_vol_pkg::VOL_RESET; // R06
            rightVol_q <= adc_vol_pkg::VOL_RESET; // R06
        end else if (wrLow) begin
            if (idx == adc_vol_pkg::IDX_LEFT_VOL) begin
                leftVol_q <= wb_dat_i[6:0]; // R07
            end
            if (idx == adc_vol_pkg::IDX_RIGHT_VOL) begin
                rightVol_q <= wb_dat_i[6:0]; // R04
            end
        end
    end

    // Phase, AGC and soft-step control registers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q    <= adc_vol_pkg::PHASE_RESET;
            agc1_q     <= adc_vol_pkg::AGC1_RESET; // R11
            stepMode_q <= adc_vol_pkg::STEP_RESET;
        end else if (wrLow) begin
            if (idx == adc_vol_pkg::IDX_PHASE) begin
                phase_q <= wb_dat_i[7:0];
            end
            if (idx == adc_vol_pkg::IDX_AGC1) begin
                agc1_q <= wb_dat_i[7:0] & adc_vol_pkg::AGC1_WMASK; // R07
            end
            if (idx == adc_vol_pkg::IDX_STEP_CTRL && wb_dat_i[1:0] != 2'h3) begin
                stepMode_q <= wb_dat_i[1:0];
            end
        end
    end

    assign agcEnable     = agc1_q[adc_vol_pkg::AGC_EN_BIT]; // R11
    assign agcTarget     = agc1_q[adc_vol_pkg::AGC_TGT_LSB +: 3]; // R12
    assign agcHysteresis = agc1_q[adc_vol_pkg::AGC_HYST_LSB +: 2];

    // Read multiplexer; status shows the applied codes the soft-stepper has reached.
    always_comb begin
        rdMux = 32'h0000_0000;
        case (idx)
            adc_vol_pkg::IDX_LEFT_VOL:  rdMux = {25'h0, leftVol_q};
            adc_vol_pkg::IDX_RIGHT_VOL: rdMux = {25'h0, rightVol_q};
            adc_vol_pkg::IDX_PHASE:     rdMux = {24'h0, phase_q};
            adc_vol_pkg::IDX_AGC1:      rdMux = {24'h0, agc1_q};
            adc_vol_pkg::IDX_STEP_CTRL: rdMux = {30'h0, stepMode_q};
            adc_vol_pkg::IDX_STATUS:    rdMux = {17'h0, rightApplied, 1'b0, leftApplied};
            default:                    rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (req) begin
            rdat_q <= rdMux;
        end
    end

    assign wb_dat_o = rdat_q;

    // Per-channel gain.
    vol_gain_channel #(.SAMPLE_W(SAMPLE_W)) uLeft (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .targetCode  (leftVol_q),
        .stepMode    (stepMode_q),
        .wordTick    (wordTick),
        .sampleIn    (leftIn),
        .sampleOut   (leftScaled),
        .appliedCode (leftApplied)
    );

    vol_gain_channel #(.SAMPLE_W(SAMPLE_W)) uRight (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .targetCode  (rightVol_q),
        .stepMode    (stepMode_q),
        .wordTick    (wordTick),
        .sampleIn    (rightIn),
        .sampleOut   (rightScaled),
        .appliedCode (rightApplied)
    );

    // Scaled samples land one cycle after the tick; the delay line samples them then.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tickDly_q <= 1'b0;
        end else begin
            tickDly_q <= wordTick;
        end
    end

    // Phase compensation: delay one channel by a whole number of words; the delay
    // amount per code is a simple magnitude here, a stand-in for finer fractional delay.
    logic signed [SAMPLE_W-1:0] hist_q [MAX_DELAY];
    logic [6:0] mag;
    logic       delayLeft;
    logic signed [SAMPLE_W-1:0] delayed;

    assign delayLeft = phase_q[7]; // R09
    assign mag       = delayLeft ? 7'(~phase_q[6:0] + 7'd1) : phase_q[6:0]; // R10
    assign delayed   = (phase_q[6:0] == 7'h00 && !delayLeft) ? '0 : hist_q[mag - 7'd1];

    always_ff @(posedge mclk) begin
        if (tickDly_q) begin
            hist_q[0] <= delayLeft ? leftScaled : rightScaled;
            for (int i = 1; i < MAX_DELAY; i++) begin
                hist_q[i] <= hist_q[i-1];
            end
        end
    end

    // Output pair; with code zero both channels pass straight through together.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            leftOut  <= '0;
            rightOut <= '0;
            outValid <= 1'b0;
        end else begin
            outValid <= tickDly_q;
            if (tickDly_q) begin
                if (phase_q == 8'h00) begin
                    leftOut  <= leftScaled; // R08
                    rightOut <= rightScaled; // R08
                end else if (delayLeft) begin
                    leftOut  <= (phase_q == 8'h80) ? hist_q[MAX_DELAY-1] : delayed; // R09
                    rightOut <= rightScaled;
                end else begin
                    leftOut  <= leftScaled;
                    rightOut <= delayed; // R10
                end
            end
        end
    end

endmodule : adc_volume_phase_agc_regs

// ### bench/adc_volume_phase_agc_regs_asserts.sv
`timescale 1ns/1ps
// Watches the register port, the gain control enable and target, and the sample timing.
module adc_volume_phase_agc_regs_asserts #(
    parameter int SAMPLE_W  = 24,
    parameter int MAX_DELAY = 128
) (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        reset_n,
    // Wishbone slave.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // Sample timing and gain control settings.
    input wire logic        wordTick,
    input wire logic        outValid,
    input wire logic        agcEnable,
    input wire logic [2:0]  agcTarget
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // A request is taken only while no answer is outstanding.
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    // A write to the gain control register is acknowledged with its byte lane enabled.
    sequence s_agc_wr;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == 8'h56;
    endsequence

    property p_answer;       s_req |=> (wb_ack_o || wb_err_o); endproperty
    property p_ack_pulse;    wb_ack_o |=> !wb_ack_o; endproperty
    property p_err_unmapped; wb_err_o |-> !(wb_adr_i[9:2] inside {8'h53, 8'h54, 8'h55, 8'h56, 8'h60, 8'h61}); endproperty
    property p_vol_top;      wb_ack_o && !wb_we_i && wb_adr_i[9:2] inside {8'h53, 8'h54} |-> wb_dat_o[31:7] == 25'h0; endproperty
    property p_agc_rsvd;     wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h56 |-> wb_dat_o[3:2] == 2'h0; endproperty
    property p_agc_write;    s_agc_wr |-> agcEnable == wb_dat_i[7] && agcTarget == wb_dat_i[6:4]; endproperty
    property p_agc_hold;     !$stable({agcEnable, agcTarget}) |-> s_agc_wr; endproperty
    property p_out_valid;    wordTick |-> ##2 outValid; endproperty
    property p_valid_cause;  outValid |-> $past(wordTick, 2); endproperty

    a_answer:       assert property (p_answer)       else $error("request not answered in one cycle");
    a_ack_pulse:    assert property (p_ack_pulse)    else $error("ack held longer than one cycle");
    a_err_unmapped: assert property (p_err_unmapped) else $error("error answer on a mapped register");
    a_vol_top:      assert property (p_vol_top)      else $error("volume top bits not zero");
    a_agc_rsvd:     assert property (p_agc_rsvd)     else $error("gain control reserved bits not zero");
    a_agc_write:    assert property (p_agc_write)    else $error("gain control outputs differ from write");
    a_agc_hold:     assert property (p_agc_hold)     else $error("gain control outputs changed without write");
    a_out_valid:    assert property (p_out_valid)    else $error("output sample late");
    a_valid_cause:  assert property (p_valid_cause)  else $error("output sample without input word");
endmodule : adc_volume_phase_agc_regs_asserts

bind adc_volume_phase_agc_regs adc_volume_phase_agc_regs_asserts #(.SAMPLE_W(SAMPLE_W), .MAX_DELAY(MAX_DELAY)) chk (
    .mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .wordTick, .outValid, .agcEnable, .agcTarget);

// ### bench/adc_volume_phase_agc_regs_tb_top.sv
`timescale 1ns/1ps
module adc_volume_phase_agc_regs_tb_top;
    logic               mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic               wordTick, outValid, agcEnable;
    logic [9:0]         wb_adr_i;
    logic [3:0]         wb_sel_i;
    logic [31:0]        wb_dat_i, wb_dat_o;
    logic signed [23:0] leftIn, rightIn, leftOut, rightOut;
    logic [2:0]         agcTarget;
    logic [1:0]         agcHysteresis;
    logic [31:0]        q;
    logic               e;
    int                 n_mismatch = 0;
    int                 checks = 0;

    adc_volume_phase_agc_regs #(.SAMPLE_W(24), .MAX_DELAY(128)) dut (.mclk, .reset_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .wordTick, .leftIn,
        .rightIn, .leftOut, .rightOut, .outValid, .agcEnable, .agcTarget, .agcHysteresis);

    // Free-running clock at 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // One classic cycle; entered just after an edge, it leaves one idle cycle behind it.
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            print_verdict();
        end
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), q, exp);
    endtask : rd

    // One sample pair; the outputs are taken at the edge that sees the valid pulse.
    task automatic word(input logic signed [23:0] l, r, el, er, input logic cmp);
        int n;
        wordTick <= 1'b1;
        leftIn   <= l;
        rightIn  <= r;
        @(posedge mclk);
        wordTick <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (outValid !== 1'b1 && n < 8);
        if (n >= 8) begin
            n_mismatch++;
            print_verdict();
        end
        if (cmp) begin
            chk("leftOut", 32'(leftOut), 32'(el));
            chk("rightOut", 32'(rightOut), 32'(er));
        end
    endtask : word

    // Reset for three cycles, then the register and sample tests in turn.
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wordTick} = 4'h0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        {leftIn, rightIn} = 48'h0;
        reset_n = 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (int i = 8'h53; i <= 8'h56; i++) rd(8'(i), 32'h00000000);
        $display("reset values done");
        bus(1'b1, 8'h53, 8'hFF);
        rd(8'h53, 32'h0000007F);
        bus(1'b1, 8'h54, 8'h28);
        rd(8'h54, 32'h00000028);
        rd(8'h53, 32'h0000007F);
        for (int t = 0; t < 8; t++) begin
            bus(1'b1, 8'h56, {1'b1, 3'(t), 4'hF});
            rd(8'h56, {24'h000000, 1'b1, 3'(t), 4'h3});
            chk("agcTarget", 32'(agcTarget), 32'(t));
            chk("agcHysteresis", 32'(agcHysteresis), 32'h00000003);
        end
        bus(1'b1, 8'h56, 8'h00);
        chk("agcEnable", 32'(agcEnable), 32'h00000000);
        bus(1'b0, 8'h57, 8'h00);
        chk("unmapped err", 32'(e), 32'h00000001);
        $display("register access done");
        // Every-word stepping moves each channel one code per word.
        word(24'sd0, 24'sd0, 24'sd0, 24'sd0, 1'b0);
        rd(8'h61, 32'h0000017F);
        bus(1'b1, 8'h60, 8'h01);
        repeat (4) word(24'sd0, 24'sd0, 24'sd0, 24'sd0, 1'b0);
        rd(8'h61, 32'h0000037F);
        bus(1'b1, 8'h60, 8'h02);
        word(24'sd0, 24'sd0, 24'sd0, 24'sd0, 1'b0);
        rd(8'h61, 32'h0000287F);
        // The unused step code 3 must leave the stepping mode as it was.
        bus(1'b1, 8'h60, 8'h03);
        rd(8'h60, 32'h00000002);
        $display("soft step done");
        // Plus 20 dB is an exact gain of ten, so truncation cannot hide a wrong table.
        bus(1'b1, 8'h53, 8'h28);
        bus(1'b1, 8'h54, 8'h00);
        word(24'sd1000, 24'sd1000, 24'sd0, 24'sd0, 1'b0);
        word(24'sd1000, 24'sd1000, 24'sd10000, 24'sd1000, 1'b1);
        bus(1'b1, 8'h53, 8'h00);
        bus(1'b1, 8'h55, 8'h01);
        word(24'sd100, 24'sd100, 24'sd0, 24'sd0, 1'b0);
        word(24'sd200, 24'sd200, 24'sd200, 24'sd100, 1'b1);
        bus(1'b1, 8'h55, 8'hFF);
        word(24'sd300, 24'sd300, 24'sd0, 24'sd0, 1'b0);
        word(24'sd400, 24'sd400, 24'sd300, 24'sd400, 1'b1);
        // Lowest usable code is a gain near one quarter; one percent covers table rounding.
        bus(1'b1, 8'h55, 8'h00);
        bus(1'b1, 8'h53, 8'h67);
        word(24'sd100000, 24'sd100000, 24'sd0, 24'sd0, 1'b0);
        chk("leftOut at -12 dB", 32'(leftOut > 24'sd24870 && leftOut < 24'sd25370), 32'h00000001);
        chk("rightOut at 0 dB", 32'(rightOut), 32'h000186A0);
        $display("sample path done");
        print_verdict();
    end
endmodule : adc_volume_phase_agc_regs_tb_top
